// File: hdl/csi_top.sv
// Codec serial interface: AHB-Lite registers, frame timing and serial shifter.
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
module csi_top #(
	parameter int DIV_W = 12
) (
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	input  wire logic        SCK_I,
	output logic             SCK_O,
	output logic             SCK_OE_O,
	input  wire logic        FS_I,
	output logic             FS_O,
	output logic             FS_OE_O,
	input  wire logic        SDI_I,
	output logic             SDO_O,
	output logic             SDO_OE_O,
	output logic             IRQ_O
);
	localparam int DEPTH = 4;

	csi_pkg::csi_ctrl_t ctrl_q;
	csi_pkg::csi_fmt_t  fmt_q;
	logic [DIV_W-1:0]   div_q;
	logic [15:0]        rxm_q;
	logic [15:0]        txm_q;
	logic [3:0]         ist_q;
	logic [3:0]         imsk_q;
	logic [3:0]         ev;
	logic               dp_q;
	logic               dwr_q;
	logic [7:0]         dadr_q;
	logic               acc;
	logic               wr;
	logic               rd;
	logic [31:0]        rmux;
	logic               sck_gen;
	logic               sck_lvl;
	logic               sck_old_q;
	logic               launch;
	logic               samp;
	logic               sdi;
	logic [4:0]         wlen;
	logic [4:0]         pbit_q;
	logic [4:0]         pbit_d;
	logic [3:0]         pslot_q;
	logic [3:0]         pslot_d;
	logic               run_q;
	logic               run_d;
	logic               fstart;
	logic [4:0]         dbit_q;
	logic [3:0]         dslot_q;
	logic               dval_q;
	logic [4:0]         nbit;
	logic [3:0]         nslot;
	logic               nval;
	logic               fs_smp_q;
	logic               fs_old_q;
	logic               fs_gen;
	logic [1:0]         txidx_q;
	logic [1:0]         rxidx_q;
	logic [3:0]         tx_new_q;
	logic [3:0]         rx_new_q;
	logic               receive_full_flag_q;
	logic [15:0]        last_q;
	logic [15:0]        tx_rdata;
	logic [15:0]        rx_rdata;
	logic [15:0]        tx_word;
	logic [19:0]        tx_load;
	logic [19:0]        tsh_q;
	logic [15:0]        rsh_q;
	logic               tx_take;
	logic               tx_act;
	logic               rx_last;
	logic [15:0]        rx_word;
	logic               twe;

	//////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: every transfer takes exactly one wait state.

	assign acc = HSEL_I & HTRANS_I[1] & HREADY_I;
	assign wr  = dp_q & dwr_q;
	assign rd  = dp_q & ~dwr_q;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			dp_q        <= 1'b0;
			dwr_q       <= 1'b0;
			dadr_q      <= '0;
			HREADYOUT_O <= 1'b1;
		end else if (acc) begin
			dp_q        <= 1'b1;
			dwr_q       <= HWRITE_I;
			dadr_q      <= HADDR_I[7:0];
			HREADYOUT_O <= 1'b0;
		end else if (dp_q) begin
			dp_q        <= 1'b0;
			HREADYOUT_O <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			HRESP_O <= 1'b0;
		end else begin
			HRESP_O <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_q <= '0;
			fmt_q  <= '0;
			div_q  <= '0;
			rxm_q  <= '0;
			txm_q  <= '0;
			imsk_q <= '0;
		end else if (wr) begin
			case (dadr_q)
				csi_pkg::OFS_CTRL1: begin
					ctrl_q.en     <= HWDATA_I[csi_pkg::BIT_EN];
					ctrl_q.loop   <= HWDATA_I[csi_pkg::BIT_LOOP];
					ctrl_q.ckdir  <= HWDATA_I[csi_pkg::BIT_CKDIR];
					ctrl_q.ckedge <= HWDATA_I[csi_pkg::BIT_CKEDGE];
					ctrl_q.fsdir  <= HWDATA_I[csi_pkg::BIT_FSDIR];
					ctrl_q.underflow_mode_bit   <= HWDATA_I[csi_pkg::BIT_UNDERFLOW_MODE_BIT];
					ctrl_q.idle   <= HWDATA_I[csi_pkg::BIT_IDLE];
					ctrl_q.justification_bit   <= HWDATA_I[csi_pkg::BIT_JUSTIFICATION_BIT];
					ctrl_q.mode   <= csi_pkg::csi_fmode_t'(HWDATA_I[1:0]);
				end
				csi_pkg::OFS_CTRL2: begin
					fmt_q.buffer_length_field <= HWDATA_I[csi_pkg::BIT_BUFFER_LENGTH_FIELD +: 2];
					fmt_q.flen <= HWDATA_I[csi_pkg::BIT_FLEN +: 4];
					fmt_q.ws   <= HWDATA_I[csi_pkg::BIT_WS +: 4];
				end
				csi_pkg::OFS_DIV:   div_q  <= HWDATA_I[DIV_W-1:0];
				csi_pkg::OFS_RXMSK: rxm_q  <= HWDATA_I[15:0];
				csi_pkg::OFS_TXMSK: txm_q  <= HWDATA_I[15:0];
				csi_pkg::OFS_IMSK:  imsk_q <= HWDATA_I[3:0];
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rmux = '0;
		case (dadr_q)
			csi_pkg::OFS_CTRL1: rmux[15:0] = {ctrl_q.en, 3'h0, ctrl_q.loop, ctrl_q.ckdir,
				ctrl_q.ckedge, ctrl_q.fsdir, ctrl_q.underflow_mode_bit, ctrl_q.idle, ctrl_q.justification_bit, 3'h0,
				ctrl_q.mode};
			csi_pkg::OFS_CTRL2: rmux[15:0] = {4'h0, fmt_q.buffer_length_field, 1'b0, fmt_q.flen, 1'b0,
				fmt_q.ws};
			csi_pkg::OFS_DIV:   rmux[DIV_W-1:0] = div_q;
			csi_pkg::OFS_STAT:  rmux[15:0] = {4'h0, dslot_q, 4'h0, ist_q[csi_pkg::IRQ_ROV],
				receive_full_flag_q, ist_q[csi_pkg::IRQ_TRANSMIT_UNDERFLOW_FLAG], ~|tx_new_q};
			csi_pkg::OFS_RXMSK: rmux[15:0] = rxm_q;
			csi_pkg::OFS_TXMSK: rmux[15:0] = txm_q;
			csi_pkg::OFS_IST:   rmux[3:0]  = ist_q;
			csi_pkg::OFS_IMSK:  rmux[3:0]  = imsk_q;
			default: begin
				if (dadr_q[7:4] == csi_pkg::OFS_RXBUF) begin
					rmux[15:0] = rx_rdata;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			HRDATA_O <= '0;
		end else if (rd) begin
			HRDATA_O <= rmux;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Interrupt status: hardware set wins over a write-one clear in one cycle.

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ist_q <= '0;
		end else if (wr && dadr_q == csi_pkg::OFS_IST) begin
			ist_q <= (ist_q & ~HWDATA_I[3:0]) | ev;
		end else begin
			ist_q <= ist_q | ev;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= |(ist_q & imsk_q);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Serial clock and edge selection.

	csi_clkdiv #(
		.DW (DIV_W)
	) u_div (
		.clk_i (CLK_I),
		.rst_i (RST_I),
		.run_i (ctrl_q.en & ~ctrl_q.ckdir),
		.div_i (div_q),
		.sck_o (sck_gen)
	);

	assign SCK_O   = sck_gen;
	assign sck_lvl = ctrl_q.ckdir ? SCK_I : sck_gen;
	assign launch  = ctrl_q.en & (ctrl_q.ckedge ? (~sck_lvl & sck_old_q)
		: (sck_lvl & ~sck_old_q));
	assign samp    = ctrl_q.en & (ctrl_q.ckedge ? (sck_lvl & ~sck_old_q)
		: (~sck_lvl & sck_old_q));
	assign sdi     = ctrl_q.loop ? SDO_O : SDI_I;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sck_old_q <= 1'b0;
			SCK_OE_O  <= 1'b0;
			FS_OE_O   <= 1'b0;
		end else begin
			sck_old_q <= ctrl_q.en & sck_lvl;
			SCK_OE_O  <= ctrl_q.en & ~ctrl_q.ckdir;
			FS_OE_O   <= ctrl_q.en & ~ctrl_q.fsdir;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Frame position; data counters lag one bit when justification is clear.

	always_comb begin
		case (ctrl_q.mode)
			csi_pkg::FM_AC20: wlen = csi_pkg::WLEN_AC20;
			csi_pkg::FM_AC16: wlen = csi_pkg::WLEN_AC16;
			default:          wlen = {1'b0, fmt_q.ws} + 5'h01;
		endcase
		if (ctrl_q.fsdir) begin
			fstart = fs_smp_q & ~fs_old_q;
		end else begin
			fstart = ~run_q | ((pbit_q == wlen - 5'h01) && (pslot_q == fmt_q.flen));
		end
		run_d = run_q | fstart;
		if (fstart) begin
			pbit_d  = '0;
			pslot_d = '0;
		end else if (pbit_q == wlen - 5'h01) begin
			pbit_d  = '0;
			pslot_d = pslot_q + 4'h1;
		end else begin
			pbit_d  = pbit_q + 5'h01;
			pslot_d = pslot_q;
		end
		nbit  = ctrl_q.justification_bit ? pbit_d : pbit_q;
		nslot = ctrl_q.justification_bit ? pslot_d : pslot_q;
		nval  = ctrl_q.justification_bit ? run_d : run_q;
		case (ctrl_q.mode)
			csi_pkg::FM_MULTI: fs_gen = (pbit_d == 5'h00) && (pslot_d == 4'h0);
			csi_pkg::FM_I2S:   fs_gen = pslot_d[0];
			default:           fs_gen = (pslot_d == 4'h0);
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pbit_q   <= '0;
			pslot_q  <= '0;
			run_q    <= 1'b0;
			dbit_q   <= '0;
			dslot_q  <= '0;
			dval_q   <= 1'b0;
			fs_smp_q <= 1'b0;
			fs_old_q <= 1'b0;
			FS_O     <= 1'b0;
		end else if (!ctrl_q.en) begin
			pbit_q   <= '0;
			pslot_q  <= '0;
			run_q    <= 1'b0;
			dbit_q   <= '0;
			dslot_q  <= '0;
			dval_q   <= 1'b0;
			fs_smp_q <= 1'b0;
			fs_old_q <= 1'b0;
			FS_O     <= 1'b0;
		end else begin
			if (samp) begin
				fs_smp_q <= FS_I;
			end
			if (launch) begin
				pbit_q   <= pbit_d;
				pslot_q  <= pslot_d;
				run_q    <= run_d;
				dbit_q   <= nbit;
				dslot_q  <= nslot;
				dval_q   <= nval;
				fs_old_q <= fs_smp_q;
				FS_O     <= ~ctrl_q.fsdir & fs_gen;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Transmit path: a word is fetched at the first bit of each enabled slot.

	assign tx_act  = nval & txm_q[nslot];
	assign tx_take = launch & tx_act & (nbit == 5'h00);

	always_comb begin
		if (tx_new_q[txidx_q]) begin
			tx_word = tx_rdata;
		end else begin
			tx_word = ctrl_q.underflow_mode_bit ? last_q : csi_pkg::RST_WORD;
		end
		tx_load = {tx_word, 4'h0} << ((wlen > csi_pkg::WLEN_AC16) ? 5'h00
			: (csi_pkg::WLEN_AC16 - wlen));
	end

	assign twe = wr & (dadr_q[7:4] == csi_pkg::OFS_TXBUF);

	csi_mem #(
		.W (16),
		.D (DEPTH)
	) u_txmem (
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.we_i    (twe),
		.waddr_i (dadr_q[3:2]),
		.wdata_i (HWDATA_I[15:0]),
		.raddr_i (txidx_q),
		.rdata_o (tx_rdata)
	);

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tsh_q    <= '0;
			last_q   <= csi_pkg::RST_WORD;
			SDO_O    <= 1'b0;
			SDO_OE_O <= 1'b0;
		end else if (!ctrl_q.en) begin
			SDO_O    <= 1'b0;
			SDO_OE_O <= 1'b0;
		end else if (launch) begin
			SDO_OE_O <= tx_act | ~ctrl_q.idle;
			if (tx_take) begin
				last_q <= tx_word;
				SDO_O  <= tx_load[19];
				tsh_q  <= tx_load << 1;
			end else begin
				SDO_O  <= tx_act & tsh_q[19];
				tsh_q  <= tsh_q << 1;
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			txidx_q  <= '0;
			tx_new_q <= '0;
		end else begin
			if (!ctrl_q.en) begin
				txidx_q <= '0;
			end else if (tx_take) begin
				txidx_q <= (txidx_q == fmt_q.buffer_length_field) ? 2'h0 : txidx_q + 2'h1;
			end
			tx_new_q <= (tx_new_q & ~({3'h0, tx_take} << txidx_q))
				| ({3'h0, twe} << dadr_q[3:2]);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Receive path: the last bit of an enabled slot writes the buffer.

	assign rx_last = samp & dval_q & rxm_q[dslot_q] & (dbit_q == wlen - 5'h01);
	assign rx_word = {rsh_q[14:0], sdi};

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rsh_q <= '0;
		end else if (samp && dval_q && rxm_q[dslot_q]) begin
			rsh_q <= rx_word;
		end
	end

	csi_mem #(
		.W (16),
		.D (DEPTH)
	) u_rxmem (
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.we_i    (rx_last),
		.waddr_i (rxidx_q),
		.wdata_i (rx_word),
		.raddr_i (HADDR_I[3:2]),
		.rdata_o (rx_rdata)
	);

	always_comb begin
		ev = '0;
		ev[csi_pkg::IRQ_TXDONE] = tx_take & (txidx_q == fmt_q.buffer_length_field);
		ev[csi_pkg::IRQ_RXFULL] = rx_last & (rxidx_q == fmt_q.buffer_length_field);
		ev[csi_pkg::IRQ_ROV]    = rx_last & rx_new_q[rxidx_q];
		ev[csi_pkg::IRQ_TRANSMIT_UNDERFLOW_FLAG]   = tx_take & ~tx_new_q[txidx_q];
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rxidx_q  <= '0;
			rx_new_q <= '0;
			receive_full_flag_q   <= 1'b0;
		end else begin
			if (!ctrl_q.en) begin
				rxidx_q <= '0;
			end else if (rx_last) begin
				rxidx_q <= (rxidx_q == fmt_q.buffer_length_field) ? 2'h0 : rxidx_q + 2'h1;
			end
			rx_new_q <= (rx_new_q & ~({3'h0, rd && dadr_q[7:4] == csi_pkg::OFS_RXBUF}
				<< dadr_q[3:2])) | ({3'h0, rx_last} << rxidx_q);
			if (ev[csi_pkg::IRQ_RXFULL]) begin
				receive_full_flag_q <= 1'b1;
			end else if (rd && dadr_q[7:4] == csi_pkg::OFS_RXBUF
				&& dadr_q[3:2] == fmt_q.buffer_length_field) begin
				receive_full_flag_q <= 1'b0;
			end
		end
	end
endmodule : csi_top

// File: hdl/csi_pkg.sv
// Constants, register map and carrier types of the codec serial interface.
// Contract
// - Loopback bit routes data output to input.
// - Clock direction bit picks clock pin direction.
// - Clock edge bit swaps change and sample edges.
// - Frame-sync direction bit picks frame pin direction.
// - Idle mode bit tri-states or zeroes disabled slots.
// - Mode field picks AC-Link 20/16, I2S, multichannel.
// - Buffer four words; length field sets interrupt spacing.
// - Frame-length field sets one to sixteen slots.
// - Word size is field value plus one.
// - Divider field sets generated bit clock rate.
// - Slot status reports currently active slot.
// - Overflow flag when unread receive word overwritten.
// - Receive-full flag when new receive data ready.
// - Underflow flag when stale transmit word needed.
// - Receive mask captures data only in enabled slots.
// - Transmit mask sends data only in enabled slots.
package csi_pkg;
	localparam logic [7:0] OFS_CTRL1 = 8'h00;
	localparam logic [7:0] OFS_CTRL2 = 8'h04;
	localparam logic [7:0] OFS_DIV   = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0c;
	localparam logic [7:0] OFS_RXMSK = 8'h10;
	localparam logic [7:0] OFS_TXMSK = 8'h14;
	localparam logic [7:0] OFS_IST   = 8'h18;
	localparam logic [7:0] OFS_IMSK  = 8'h1c;
	localparam logic [3:0] OFS_TXBUF = 4'h2;
	localparam logic [3:0] OFS_RXBUF = 4'h3;
	localparam int BIT_EN     = 15;
	localparam int BIT_LOOP   = 11;
	localparam int BIT_CKDIR  = 10;
	localparam int BIT_CKEDGE = 9;
	localparam int BIT_FSDIR  = 8;
	localparam int BIT_UNDERFLOW_MODE_BIT   = 7;
	localparam int BIT_IDLE   = 6;
	localparam int BIT_JUSTIFICATION_BIT   = 5;
	localparam int BIT_BUFFER_LENGTH_FIELD   = 10;
	localparam int BIT_FLEN   = 5;
	localparam int BIT_WS     = 0;
	localparam int IRQ_TXDONE = 0;
	localparam int IRQ_RXFULL = 1;
	localparam int IRQ_ROV    = 2;
	localparam int IRQ_TRANSMIT_UNDERFLOW_FLAG   = 3;
	localparam logic [4:0] WLEN_AC20  = 5'h14;
	localparam logic [4:0] WLEN_AC16  = 5'h10;
	localparam logic [4:0] SHIFT_W    = 5'h14;
	localparam logic [15:0] RST_WORD  = 16'h0000;

	typedef enum logic [1:0] {FM_MULTI, FM_I2S, FM_AC16, FM_AC20} csi_fmode_t;

	typedef struct packed {
		logic       en;
		logic       loop;
		logic       ckdir;
		logic       ckedge;
		logic       fsdir;
		logic       underflow_mode_bit;
		logic       idle;
		logic       justification_bit;
		csi_fmode_t mode;
	} csi_ctrl_t;

	typedef struct packed {
		logic [1:0] buffer_length_field;
		logic [3:0] flen;
		logic [3:0] ws;
	} csi_fmt_t;
endpackage : csi_pkg

// File: hdl/csi_clkdiv.sv
// Bit-clock generator: output toggles every div_i+1 clock cycles.
`timescale 1ns/100ps
module csi_clkdiv #(
	parameter int DW = 12
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          run_i,
	input  wire logic [DW-1:0] div_i,
	output logic               sck_o
);
	logic [DW-1:0] cnt_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			sck_o <= 1'b0;
		end else if (!run_i) begin
			cnt_q <= '0;
			sck_o <= 1'b0;
		end else if (cnt_q >= div_i) begin
			cnt_q <= '0;
			sck_o <= ~sck_o;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule : csi_clkdiv

// File: hdl/csi_mem.sv
// Small sample buffer with one write port and a registered read port.
`timescale 1ns/100ps
module csi_mem #(
	parameter int W = 16,
	parameter int D = 4
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 we_i,
	input  wire logic [$clog2(D)-1:0] waddr_i,
	input  wire logic [W-1:0]         wdata_i,
	input  wire logic [$clog2(D)-1:0] raddr_i,
	output logic      [W-1:0]         rdata_o
);
	logic [W-1:0] mem [D];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule : csi_mem

// File: dv/csi_codec_model.sv
// Behavioural codec on the far side of the serial pins.
`timescale 1ns/100ps
module csi_codec_model (
	input  wire logic clk_i,
	input  wire logic sck_oe_i,
	input  wire logic fs_oe_i,
	input  wire logic lvl_i,
	output logic      sck_o,
	output logic      fs_o,
	output logic      sdi_o
);
	////////////////////////////////////////////////////////////////
	// The codec leaves the clock pin to the device and never runs it itself.
	assign sck_o = 1'b0;
	initial begin
		fs_o = 1'b0;
		sdi_o = 1'b0;
	end
	// An undriven frame pin wanders every cycle; data in holds lvl_i while the device drives the clock, else wanders.
	always @(posedge clk_i) begin
		fs_o <= fs_oe_i ? 1'b0 : !fs_o;
		sdi_o <= sck_oe_i ? lvl_i : !sdi_o;
	end
endmodule : csi_codec_model

// File: dv/csi_checker.sv
// Port-level assertions of the codec serial interface.
`timescale 1ns/100ps
module csi_checker (
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0]  HTRANS_I,
	input wire logic        HWRITE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic        HREADY_I,
	input wire logic [31:0] HRDATA_O,
	input wire logic        HREADYOUT_O,
	input wire logic        HRESP_O,
	input wire logic        SCK_O,
	input wire logic        SCK_OE_O,
	input wire logic        FS_O,
	input wire logic        FS_OE_O,
	input wire logic        SDO_O,
	input wire logic        SDO_OE_O,
	input wire logic        IRQ_O
);
	logic        wr_q;
	logic [7:0]  wa_q;
	logic [15:0] ctrl_q;
	logic [15:0] txm_q;
	logic [15:0] msk_q;
	logic [7:0]  age_q;
	////////////////////////////////////////////////////////////////
	// A shadow of the control, transmit-mask and interrupt-mask registers, committed one edge after the address phase.
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
		end else begin
			wr_q <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
			if (HREADY_I) wa_q <= HADDR_I[7:0];
		end
	end
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_q <= 16'h0000;
			txm_q <= 16'h0000;
			msk_q <= 16'h0000;
			age_q <= 8'h00;
		end else begin
			age_q <= wr_q ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
			if (wr_q && wa_q == 8'h00) ctrl_q <= HWDATA_I[15:0];
			if (wr_q && wa_q == 8'h14) txm_q <= HWDATA_I[15:0];
			if (wr_q && wa_q == 8'h1c) msk_q <= HWDATA_I[15:0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	a_one_wait: assert property (HSEL_I && HTRANS_I[1] && HREADY_I |=> !HREADYOUT_O ##1 HREADYOUT_O)
		else $error("bus answer not after one wait state");
	a_resp_okay: assert property (!HRESP_O && HRDATA_O[31:16] == 16'h0000)
		else $error("bad response or upper read bits");
	a_off_quiet: assert property (!ctrl_q[15] && !$past(ctrl_q[15]) |-> !SCK_OE_O && !FS_OE_O && !SDO_OE_O)
		else $error("disabled module drives a pin");
	a_clock_dir: assert property ($stable(ctrl_q) |-> SCK_OE_O == (ctrl_q[15] && !ctrl_q[10]))
		else $error("clock pin direction wrong");
	a_fsync_dir: assert property ($stable(ctrl_q) |-> FS_OE_O == (ctrl_q[15] && !ctrl_q[8]))
		else $error("frame pin direction wrong");
	a_idle_level: assert property (age_q > 8'd40 && ctrl_q[15] && txm_q == 16'h0000
		|-> !SDO_O && SDO_OE_O == !ctrl_q[6])
		else $error("disabled slot output wrong");
	a_launch_edge: assert property (age_q > 8'd40 && ctrl_q[15] && !ctrl_q[10]
		&& ($changed(SDO_O) || $changed(FS_O)) |-> SCK_O == !ctrl_q[9])
		else $error("output changed on the sample edge");
	a_irq_masked: assert property (msk_q == 16'h0000 && $past(msk_q) == 16'h0000 |-> !IRQ_O)
		else $error("interrupt raised while masked");
endmodule : csi_checker

bind csi_top csi_checker u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I),
	.HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I),
	.HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
	.HRESP_O(HRESP_O), .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O), .FS_O(FS_O),
	.FS_OE_O(FS_OE_O), .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O), .IRQ_O(IRQ_O));

// File: dv/csi_top_tb.sv
// Register-level bench of the codec serial interface.
`timescale 1ns/100ps
module csi_top_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hready, hresp, sck_o, sck_oe, fs_o, fs_oe, sdo, sdo_oe, irq;
	logic        p_sck, p_fs, p_sdi;
	logic        lvl = 1'b1;
	logic [15:0] r, seen;
	int          n;
	int          error_cnt = 0;
	int          checks_done = 0;
	logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h40};
	logic [7:0]  cfg_a [4] = '{8'h08, 8'h04, 8'h10, 8'h14};
	logic [15:0] cfg_d [4] = '{16'h0003, 16'h042f, 16'h0003, 16'h0003};
	always #5 clk = !clk;
	csi_top dut (.CLK_I(clk), .RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.SCK_I(sck_oe ? sck_o : p_sck), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
		.FS_I(fs_oe ? fs_o : p_fs), .FS_O(fs_o), .FS_OE_O(fs_oe),
		.SDI_I(p_sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .IRQ_O(irq));
	csi_codec_model codec (.clk_i(clk), .sck_oe_i(sck_oe), .fs_oe_i(fs_oe), .lvl_i(lvl),
		.sck_o(p_sck), .fs_o(p_fs), .sdi_o(p_sdi));
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
		checks_done++;
		if (seen_v !== exp_v) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen_v, exp_v);
		end
	endtask : chk
	task automatic hold;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hready !== 1'b1 && k < 20);
		if (k == 20) begin
			chk(16'h0, 16'h1);
			report_and_stop();
		end
	endtask : hold
	// Called just after an edge; read data lands in r at the completing edge.
	task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hold();
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		hold();
		r = hrdata[15:0];
	endtask : bus
	task automatic wait_stat(input logic [15:0] m);
		int k;
		k = 0;
		do begin
			bus(8'h0c, 1'b0, 16'h0);
			k++;
		end while ((r & m) !== m && k < 400);
		chk(r & m, m);
		if (k == 400) report_and_stop();
	endtask : wait_stat
	task automatic wait_sck(input logic v);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sck_o !== v && n < 50);
		if (n == 50) begin
			chk(16'h0, 16'h1);
			report_and_stop();
		end
	endtask : wait_sck
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (ofs[i]) begin
			bus(ofs[i], 1'b0, 16'h0);
			chk(r, 16'h0);
		end
		chk({13'h0, sck_oe, fs_oe, sdo_oe}, 16'h0);
		bus(8'h0c, 1'b1, 16'hffff);
		bus(8'h0c, 1'b0, 16'h0);
		chk(r & 16'h0f0e, 16'h0);
		foreach (cfg_a[i]) begin
			bus(cfg_a[i], 1'b1, cfg_d[i]);
			bus(cfg_a[i], 1'b0, 16'h0);
			chk(r, cfg_d[i]);
		end
		// Two slots in loopback; later passes use the other edge, underflow repeat,
		// late justification and then 16-bit AC-Link framing.
		for (int it = 0; it < 3; it++) begin
			bus(8'h20, 1'b1, 16'h1234);
			bus(8'h24, 1'b1, 16'h5678);
			bus(8'h34, 1'b0, 16'h0);
			bus(8'h00, 1'b1, (it == 0) ? 16'h8860 : ((it == 1) ? 16'h8ac0 : 16'h8ac2));
			wait_stat(16'h0004);
			bus(8'h30, 1'b0, 16'h0);
			chk(r, 16'h1234);
			bus(8'h34, 1'b0, 16'h0);
			chk(r, 16'h5678);
			wait_stat(16'h0006);
			bus(8'h34, 1'b0, 16'h0);
			chk(r, it ? 16'h5678 : 16'h0);
			wait_stat(16'h0008);
			seen = 16'h0;
			repeat (120) begin
				bus(8'h0c, 1'b0, 16'h0);
				seen[r[11:8]] = 1'b1;
			end
			chk(seen, 16'h0003);
			wait_sck(1'b0);
			wait_sck(1'b1);
			wait_sck(1'b0);
			chk(16'(n), 16'h0004);
			bus(8'h1c, 1'b1, 16'h0008);
			repeat (3) @(posedge clk);
			chk({15'h0, irq}, 16'h1);
			bus(8'h1c, 1'b1, 16'h0);
			repeat (3) @(posedge clk);
			chk({15'h0, irq}, 16'h0);
			bus(8'h00, 1'b1, 16'h0);
			bus(8'h18, 1'b1, 16'h000f);
			bus(8'h18, 1'b0, 16'h0);
			chk(r, 16'h0);
		end
		bus(8'h34, 1'b0, 16'h0);
		bus(8'h00, 1'b1, 16'h8060);
		wait_stat(16'h0004);
		bus(8'h30, 1'b0, 16'h0);
		chk(r, 16'hffff);
		chk({14'h0, sck_oe, fs_oe}, 16'h0003);
		bus(8'h10, 1'b1, 16'h0);
		bus(8'h34, 1'b0, 16'h0);
		repeat (600) @(posedge clk);
		bus(8'h0c, 1'b0, 16'h0);
		chk(r & 16'h0004, 16'h0);
		bus(8'h14, 1'b1, 16'h0);
		bus(8'h00, 1'b1, 16'h8000);
		repeat (40) @(posedge clk);
		chk({14'h0, sdo_oe, sdo}, 16'h0002);
		bus(8'h00, 1'b1, 16'h8040);
		repeat (40) @(posedge clk);
		chk({15'h0, sdo_oe}, 16'h0);
		bus(8'h00, 1'b1, 16'h8500);
		repeat (3) @(posedge clk);
		chk({14'h0, sck_oe, fs_oe}, 16'h0);
		bus(8'h00, 1'b1, 16'h0);
		repeat (3) @(posedge clk);
		chk({13'h0, sck_oe, fs_oe, sdo_oe}, 16'h0);
		report_and_stop();
	end
endmodule : csi_top_tb
